//--- hw/dcfg_defs.svh
// Offsets, field positions, reset values and timing counts of the driver
// configuration register bank. Included by the package and the design.
`ifndef DCFG_DEFS_SVH
`define DCFG_DEFS_SVH

// Register indices; byte address is four times the index
`define DCFG_IDX_HS_OPEN_LOAD   6'h1f
`define DCFG_IDX_HS7_TRIP       6'h20
`define DCFG_IDX_HS_CONST_CUR   6'h21
`define DCFG_IDX_HS_PWM_FREQ    6'h22
`define DCFG_IDX_HEATER         6'h23
`define DCFG_IDX_EC             6'h24
`define DCFG_IDX_HS8_12_TRIP    6'h25
`define DCFG_IDX_SPARE          6'h26
`define DCFG_NUM_REGS           8

// Writable bit masks (reserved bits read zero)
`define DCFG_MASK_HS_OPEN_LOAD  16'h003f
`define DCFG_MASK_HS7_TRIP      16'h008f
`define DCFG_MASK_HS_CONST_CUR  16'h3f3f
`define DCFG_MASK_HS_PWM_FREQ   16'h0fff
`define DCFG_MASK_HEATER        16'h0ffe
`define DCFG_MASK_EC            16'hff3f
`define DCFG_MASK_HS8_12_TRIP   16'h0f1f
`define DCFG_MASK_SPARE         16'h0000

// Reset values
`define DCFG_RST_ZERO           16'h0000
`define DCFG_RST_HEATER         16'h0a3c

// Constant-current limits in mA
`define DCFG_CC_LOW_MA          9'd350
`define DCFG_CC_HIGH_MA         9'd450
`define DCFG_CC7_HIGHR_LOW_MA   9'd250
`define DCFG_CC7_HIGHR_HIGH_MA  9'd330
`define DCFG_CC7_LOWR_LOW_MA    9'd360
`define DCFG_CC7_LOWR_HIGH_MA   9'd450

// EC target maximum in mV
`define DCFG_EC_MAX_LOW_MV      11'd1200
`define DCFG_EC_MAX_HIGH_MV     11'd1500

// Trip deglitch times in us and their cycle counts at the system clock
`define DCFG_CLK_MHZ            25
`define DCFG_TRIP_DG0_US        48
`define DCFG_TRIP_DG1_US        40
`define DCFG_TRIP_DG2_US        32
`define DCFG_TRIP_DG3_US        24
`define DCFG_TRIP_DG0_CYC       11'(`DCFG_TRIP_DG0_US * `DCFG_CLK_MHZ)
`define DCFG_TRIP_DG1_CYC       11'(`DCFG_TRIP_DG1_US * `DCFG_CLK_MHZ)
`define DCFG_TRIP_DG2_CYC       11'(`DCFG_TRIP_DG2_US * `DCFG_CLK_MHZ)
`define DCFG_TRIP_DG3_CYC       11'(`DCFG_TRIP_DG3_US * `DCFG_CLK_MHZ)

`endif

//--- hw/dcfg_pkg.sv
// Types of the driver configuration register bank.
// Assumes dcfg_defs.svh on the include path.
`include "dcfg_defs.svh"

package dcfg_pkg;

    typedef enum logic [1:0] {DCFG_HT_LATCH, DCFG_HT_CYCLE, DCFG_HT_WARN, DCFG_HT_OFF} dcfg_heat_mode_t;
    typedef enum logic [1:0] {DCFG_DG_OFF, DCFG_DG_SHORT, DCFG_DG_OPEN, DCFG_DG_OFF2} dcfg_ec_diag_t;
    typedef enum logic [1:0] {DCFG_OV_NONE, DCFG_OV_REPORT, DCFG_OV_PULL, DCFG_OV_RSVD} dcfg_ec_ov_t;

    // Raw configuration fields towards the analog drivers (index 0 is driver 7)
    typedef struct packed {
        logic [5:0]       hs_open_load_enable;
        logic             hs7_trip_regulation_enable;
        logic [1:0]       hs7_trip_frequency;
        logic [1:0]       hs7_trip_deglitch;
        logic [5:0]       hs_const_current_limit;
        logic [5:0]       hs_const_current_enable;
        logic [5:0][1:0]  hs_pwm_gen_frequency;
        logic [3:0]       heater_drain_threshold;
        dcfg_heat_mode_t  heater_drain_fault_mode;
        logic [1:0]       heater_drain_blanking;
        logic [1:0]       heater_drain_deglitch;
        logic             heater_offline_open_load_enable;
        dcfg_ec_diag_t    ec_feedback_diag_select;
        logic [1:0]       ec_supply_overcurrent_deglitch;
        logic [1:0]       ec_short_resistance_select;
        logic [1:0]       ec_overvoltage_deglitch;
        dcfg_ec_ov_t      ec_overvoltage_response;
        logic             ec_overcurrent_response;
        logic             ec_lowside_pwm_discharge;
        logic             ec_discharge_open_load_enable;
        logic             ec_max_target_select;
        logic [1:0]       hs_shared_trip_frequency;
        logic [1:0]       hs_shared_trip_deglitch;
        logic [4:0]       hs8_trip_regulation_enable;
    } dcfg_cfg_t;

    // Decoded values
    typedef struct packed {
        logic [5:0][8:0]  cc_limit_ma;
        logic [10:0]      hs7_trip_dg_cycles;
        logic [10:0]      hs_shared_trip_dg_cycles;
        logic [10:0]      ec_max_target_mv;
        logic             heater_monitor_active;
        logic             ec_ov_pull_gate_low;
    } dcfg_dec_t;

endpackage

//--- hw/dcfg_top.sv
// Driver configuration register bank behind an APB slave.
// Assumes an APB master on sys_clk; the on-resistance mode of driver 7
// comes from a neighbouring register as a level input.
//
// Functional notes
// - Per-driver open-load enables, bits 0-5
// - Bit 7 enables driver 7 trip regulation
// - Driver 7 trip frequency two-bit select
// - Driver 7 trip deglitch 48/40/32/24 us
// - Drivers 8-12 current limit 350/450 mA
// - Driver 7 limit depends on resistance mode
// - Per-driver constant-current enables, bits 0-5
// - Per-driver two-bit PWM generator frequency
// - Heater drain threshold bits 11-8, reset A
// - Heater overcurrent response mode select
// - Heater blanking and deglitch, reset 3
// - Heater offline open-load enable, bit 1
// - EC diagnostic select and short resistance
// - EC supply overcurrent deglitch select
// - EC overvoltage deglitch select
// - EC overvoltage response, none, report or pull
// - EC overcurrent response, hi-Z or retry
// - EC low-side PWM discharge select
// - EC discharge open-load enable
// - EC maximum target 1.2 or 1.5 V
// - Shared trip frequency and deglitch 8-12
// - Seventh register bits 0-4 trip enables
`timescale 1ns/1ns
`include "dcfg_defs.svh"
`default_nettype none

module dcfg_top
    import dcfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        hs7_on_resistance_mode,
    output dcfg_cfg_t        cfg,
    output dcfg_dec_t        dec
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] slot_of(input logic [5:0] idx);
        slot_of = 3'(idx - `DCFG_IDX_HS_OPEN_LOAD);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[1:0] == 2'h0) && (addr[7:2] >= `DCFG_IDX_HS_OPEN_LOAD)
            && (addr[7:2] <= `DCFG_IDX_SPARE);
    endfunction

    function automatic logic [15:0] mask_of(input logic [2:0] s);
        case (s)
            3'h0:    mask_of = `DCFG_MASK_HS_OPEN_LOAD;
            3'h1:    mask_of = `DCFG_MASK_HS7_TRIP;
            3'h2:    mask_of = `DCFG_MASK_HS_CONST_CUR;
            3'h3:    mask_of = `DCFG_MASK_HS_PWM_FREQ;
            3'h4:    mask_of = `DCFG_MASK_HEATER;
            3'h5:    mask_of = `DCFG_MASK_EC;
            3'h6:    mask_of = `DCFG_MASK_HS8_12_TRIP;
            default: mask_of = `DCFG_MASK_SPARE;
        endcase
    endfunction

    function automatic logic [10:0] trip_dg_cycles(input logic [1:0] code);
        case (code)
            2'h0:    trip_dg_cycles = `DCFG_TRIP_DG0_CYC;
            2'h1:    trip_dg_cycles = `DCFG_TRIP_DG1_CYC;
            2'h2:    trip_dg_cycles = `DCFG_TRIP_DG2_CYC;
            default: trip_dg_cycles = `DCFG_TRIP_DG3_CYC;
        endcase
    endfunction

    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    logic [15:0] regs [`DCFG_NUM_REGS];
    logic        access;
    logic        hit;
    logic [2:0]  slot;
    logic        do_write;
    logic [15:0] lane_mask;

    assign access    = psel && penable;
    assign hit       = mapped(paddr);
    assign slot      = slot_of(paddr[7:2]);
    assign do_write  = access && pready && pwrite && hit;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !hit;
            if (access && !pready)
                prdata <= (hit && !pwrite) ? {16'h0000, regs[slot] & mask_of(slot)} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `DCFG_NUM_REGS; gi++)
        begin : g_reg
            logic [15:0] wmask;
            assign wmask = mask_of(3'(gi)) & lane_mask;
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                    regs[gi] <= (gi == 4) ? `DCFG_RST_HEATER : `DCFG_RST_ZERO;
                else if (do_write && slot == 3'(gi))
                    regs[gi] <= (regs[gi] & ~wmask) | (pwdata[15:0] & wmask);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------
    logic [15:0] r_ol;
    logic [15:0] r_t7;
    logic [15:0] r_cc;
    logic [15:0] r_pw;
    logic [15:0] r_ht;
    logic [15:0] r_ec;
    logic [15:0] r_t8;

    assign r_ol = regs[0];
    assign r_t7 = regs[1];
    assign r_cc = regs[2];
    assign r_pw = regs[3];
    assign r_ht = regs[4];
    assign r_ec = regs[5];
    assign r_t8 = regs[6];

    assign cfg.hs_open_load_enable             = r_ol[5:0];
    assign cfg.hs7_trip_regulation_enable      = r_t7[7];
    assign cfg.hs7_trip_frequency              = r_t7[3:2];
    assign cfg.hs7_trip_deglitch               = r_t7[1:0];
    assign cfg.hs_const_current_limit          = r_cc[13:8];
    assign cfg.hs_const_current_enable         = r_cc[5:0];
    assign cfg.heater_drain_threshold          = r_ht[11:8];
    assign cfg.heater_drain_fault_mode         = dcfg_heat_mode_t'(r_ht[7:6]);
    assign cfg.heater_drain_blanking           = r_ht[5:4];
    assign cfg.heater_drain_deglitch           = r_ht[3:2];
    assign cfg.heater_offline_open_load_enable = r_ht[1];
    assign cfg.ec_feedback_diag_select         = dcfg_ec_diag_t'(r_ec[15:14]);
    assign cfg.ec_supply_overcurrent_deglitch  = r_ec[13:12];
    assign cfg.ec_short_resistance_select      = r_ec[11:10];
    assign cfg.ec_overvoltage_deglitch         = r_ec[9:8];
    assign cfg.ec_overvoltage_response         = dcfg_ec_ov_t'(r_ec[5:4]);
    assign cfg.ec_overcurrent_response         = r_ec[3];
    assign cfg.ec_lowside_pwm_discharge        = r_ec[2];
    assign cfg.ec_discharge_open_load_enable   = r_ec[1];
    assign cfg.ec_max_target_select            = r_ec[0];
    assign cfg.hs_shared_trip_frequency        = r_t8[11:10];
    assign cfg.hs_shared_trip_deglitch         = r_t8[9:8];
    assign cfg.hs8_trip_regulation_enable      = r_t8[4:0];

    // ------------------------------------------------------------
    // Per-driver decode
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_drv
            assign cfg.hs_pwm_gen_frequency[gi] = r_pw[2*gi+1:2*gi];
            if (gi == 0)
            begin : g_hs7
                // Driver 7 limit follows its on-resistance mode
                assign dec.cc_limit_ma[gi] = hs7_on_resistance_mode
                    ? (r_cc[8] ? `DCFG_CC7_LOWR_HIGH_MA : `DCFG_CC7_LOWR_LOW_MA)
                    : (r_cc[8] ? `DCFG_CC7_HIGHR_HIGH_MA : `DCFG_CC7_HIGHR_LOW_MA);
            end
            else
            begin : g_hsn
                assign dec.cc_limit_ma[gi] = r_cc[8+gi] ? `DCFG_CC_HIGH_MA : `DCFG_CC_LOW_MA;
            end
        end
    endgenerate

    assign dec.hs7_trip_dg_cycles       = trip_dg_cycles(r_t7[1:0]);
    assign dec.hs_shared_trip_dg_cycles = trip_dg_cycles(r_t8[9:8]);
    assign dec.ec_max_target_mv         = r_ec[0] ? `DCFG_EC_MAX_HIGH_MV : `DCFG_EC_MAX_LOW_MV;
    assign dec.heater_monitor_active    = (r_ht[7:6] != 2'h3);
    assign dec.ec_ov_pull_gate_low      = (r_ec[5:4] == 2'h2);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_wr(logic [5:0] idx);
        psel && penable && pready && pwrite && paddr == {idx, 2'h0} && pstrb[0];
    endsequence

    sequence s_wrh(logic [5:0] idx);
        psel && penable && pready && pwrite && paddr == {idx, 2'h0} && pstrb[1];
    endsequence

    a_ol_enable_write: assert property (
        s_wr(`DCFG_IDX_HS_OPEN_LOAD) |=> cfg.hs_open_load_enable == $past(pwdata[5:0]))
        else $error("open-load enables not stored");

    a_hs7_trip_write: assert property (
        s_wr(`DCFG_IDX_HS7_TRIP) |=> cfg.hs7_trip_regulation_enable == $past(pwdata[7])
            && cfg.hs7_trip_frequency == $past(pwdata[3:2]))
        else $error("driver 7 trip fields not stored");

    a_hs7_dg_cycles: assert property (
        cfg.hs7_trip_deglitch == 2'h0 |-> dec.hs7_trip_dg_cycles == 11'd1200)
        else $error("driver 7 deglitch count wrong");

    a_cc7_limit_mode: assert property (
        hs7_on_resistance_mode && r_cc[8] |-> dec.cc_limit_ma[0] == 9'd450)
        else $error("driver 7 low-resistance limit wrong");

    a_cc_enable_write: assert property (
        s_wr(`DCFG_IDX_HS_CONST_CUR) |=> cfg.hs_const_current_enable == $past(pwdata[5:0]))
        else $error("constant-current enables not stored");

    a_heat_thr_write: assert property (
        s_wrh(`DCFG_IDX_HEATER) |=> cfg.heater_drain_threshold == $past(pwdata[11:8]))
        else $error("heater threshold not stored");

    a_heat_reset_val: assert property (
        $rose(rstn) |-> cfg.heater_drain_blanking == 2'h3 && cfg.heater_drain_deglitch == 2'h3)
        else $error("heater timing reset value wrong");

    a_ec_hold_value: assert property (
        !(psel && penable && pready && pwrite && paddr[7:2] == `DCFG_IDX_EC) |=> $stable(r_ec))
        else $error("EC register changed without a write");

    a_ec_ov_pull: assert property (
        s_wr(`DCFG_IDX_EC) ##0 pwdata[5:4] == 2'h2 |=> dec.ec_ov_pull_gate_low)
        else $error("overvoltage pull-low not selected");

    a_trip8_write: assert property (
        s_wr(`DCFG_IDX_HS8_12_TRIP) |=> cfg.hs8_trip_regulation_enable == $past(pwdata[4:0]))
        else $error("driver 8-12 trip enables not stored");

    a_unmapped_err: assert property (
        psel && penable && !pready && !mapped(paddr) |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    a_hs7_dg_write: assert property (
        s_wr(`DCFG_IDX_HS7_TRIP) |=> cfg.hs7_trip_deglitch == $past(pwdata[1:0]))
        else $error("driver 7 deglitch not stored");

    a_cc_limit_write: assert property (
        s_wrh(`DCFG_IDX_HS_CONST_CUR) |=> cfg.hs_const_current_limit == $past(pwdata[13:8]))
        else $error("current limits not stored");

    a_cc8_limit_val: assert property (
        dec.cc_limit_ma[1] == (r_cc[9] ? 9'd450 : 9'd350))
        else $error("driver 8 limit wrong");

    a_cc12_limit_val: assert property (
        dec.cc_limit_ma[5] == (r_cc[13] ? 9'd450 : 9'd350))
        else $error("driver 12 limit wrong");

    a_cc7_high_res: assert property (
        !hs7_on_resistance_mode |-> dec.cc_limit_ma[0] == (r_cc[8] ? 9'd330 : 9'd250))
        else $error("driver 7 high-resistance limit wrong");

    a_pwm_freq_write: assert property (
        s_wr(`DCFG_IDX_HS_PWM_FREQ) ##0 pstrb[1] |=> cfg.hs_pwm_gen_frequency == $past(pwdata[11:0]))
        else $error("PWM frequencies not stored");

    a_heat_mode_write: assert property (
        s_wr(`DCFG_IDX_HEATER) |=> cfg.heater_drain_fault_mode == $past(pwdata[7:6]))
        else $error("heater fault mode not stored");

    a_heat_mon_off: assert property (
        dec.heater_monitor_active == (cfg.heater_drain_fault_mode != DCFG_HT_OFF))
        else $error("heater monitor activity wrong");

    a_heat_time_write: assert property (
        s_wr(`DCFG_IDX_HEATER) |=> {cfg.heater_drain_blanking, cfg.heater_drain_deglitch} == $past(pwdata[5:2]))
        else $error("heater timing not stored");

    a_heat_thr_reset: assert property (
        $rose(rstn) |-> cfg.heater_drain_threshold == 4'ha)
        else $error("heater threshold reset value wrong");

    a_heat_olp_write: assert property (
        s_wr(`DCFG_IDX_HEATER) |=> cfg.heater_offline_open_load_enable == $past(pwdata[1]))
        else $error("heater open-load enable not stored");

    a_ec_diag_write: assert property (
        s_wrh(`DCFG_IDX_EC) |=> cfg.ec_feedback_diag_select == $past(pwdata[15:14])
            && cfg.ec_short_resistance_select == $past(pwdata[11:10]))
        else $error("EC diagnostic fields not stored");

    a_ec_ocp_dg_write: assert property (
        s_wrh(`DCFG_IDX_EC) |=> cfg.ec_supply_overcurrent_deglitch == $past(pwdata[13:12]))
        else $error("EC supply deglitch not stored");

    a_ec_ov_dg_write: assert property (
        s_wrh(`DCFG_IDX_EC) |=> cfg.ec_overvoltage_deglitch == $past(pwdata[9:8]))
        else $error("EC overvoltage deglitch not stored");

    a_ec_ov_write: assert property (
        s_wr(`DCFG_IDX_EC) |=> cfg.ec_overvoltage_response == $past(pwdata[5:4]))
        else $error("EC overvoltage response not stored");

    a_ec_oc_write: assert property (
        s_wr(`DCFG_IDX_EC) |=> cfg.ec_overcurrent_response == $past(pwdata[3]))
        else $error("EC overcurrent response not stored");

    a_ec_pwm_write: assert property (
        s_wr(`DCFG_IDX_EC) |=> cfg.ec_lowside_pwm_discharge == $past(pwdata[2]))
        else $error("EC discharge mode not stored");

    a_ec_discharge_open_load_enable_write: assert property (
        s_wr(`DCFG_IDX_EC) |=> cfg.ec_discharge_open_load_enable == $past(pwdata[1]))
        else $error("EC discharge open-load not stored");

    a_ec_max_val: assert property (
        dec.ec_max_target_mv == (cfg.ec_max_target_select ? 11'd1500 : 11'd1200))
        else $error("EC target maximum wrong");

    a_trip8_time_write: assert property (
        s_wrh(`DCFG_IDX_HS8_12_TRIP) |=> cfg.hs_shared_trip_frequency == $past(pwdata[11:10])
            && cfg.hs_shared_trip_deglitch == $past(pwdata[9:8]))
        else $error("shared trip timing not stored");

    a_trip8_dg_val: assert property (
        cfg.hs_shared_trip_deglitch == 2'h3 |-> dec.hs_shared_trip_dg_cycles == 11'd600)
        else $error("shared deglitch count wrong");

    a_ol_reserved: assert property (
        r_ol[15:6] == 10'h000)
        else $error("open-load reserved bits set");

    a_ready_one: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error without ready");

    a_spare_read_zero: assert property (
        psel && penable && !pready && !pwrite && paddr == {`DCFG_IDX_SPARE, 2'h0}
            |=> prdata == 32'h0000_0000 && !pslverr)
        else $error("spare register read not zero");

    a_read_hi_zero: assert property (
        psel && penable && !pready |=> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");

endmodule

`default_nettype wire

//--- sim/dcfg_top_bench.sv
// Self-checking bench for the driver configuration register bank.
// Assumes dcfg_defs.svh on the include path and dcfg_pkg compiled first.
`timescale 1ns/1ns
`include "dcfg_defs.svh"
`default_nettype none

module dcfg_top_bench
    import dcfg_pkg::*;
;
    logic        sys_clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        hs7_on_resistance_mode;
    dcfg_cfg_t   cfg;
    dcfg_dec_t   dec;
    int          mismatches;
    int          num_checks;
    logic [15:0] r [0:7];
    logic [15:0] msk [0:7];
    logic [31:0] rdv;
    logic        errv;

    dcfg_top dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .hs7_on_resistance_mode(hs7_on_resistance_mode), .cfg(cfg), .dec(dec));

    // ------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 10000);
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------
    // APB access and comparison tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] adr(input int k);
        return 8'((`DCFG_IDX_HS_OPEN_LOAD + k) * 4);
    endfunction

    task automatic wr(input int k, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] m;
        m = msk[k] & {{8{s[1]}}, {8{s[0]}}};
        apb(1'b1, adr(k), d, s);
        r[k] = (r[k] & ~m) | (d & m);
        chk(16'(errv), 16'h0000);
    endtask

    task automatic rd_all();
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b0, adr(k), 16'h0000, 4'h0);
            chk(rdv[15:0], r[k]);
            chk(rdv[31:16] | 16'(errv), 16'h0000);
        end
    endtask

    task automatic check_fields();
        @(negedge sys_clk);
        chk(16'(cfg.hs_open_load_enable), r[0][5:0]);
        chk(16'(cfg.hs7_trip_regulation_enable), r[1][7]);
        chk(16'(cfg.hs7_trip_frequency), r[1][3:2]);
        chk(16'(cfg.hs7_trip_deglitch), r[1][1:0]);
        chk(16'(cfg.hs_const_current_limit), r[2][13:8]);
        chk(16'(cfg.hs_const_current_enable), r[2][5:0]);
        chk(16'(cfg.hs_pwm_gen_frequency), r[3][11:0]);
        chk(16'(cfg.heater_drain_threshold), r[4][11:8]);
        chk(16'(cfg.heater_drain_fault_mode), r[4][7:6]);
        chk({cfg.heater_drain_blanking, cfg.heater_drain_deglitch}, r[4][5:2]);
        chk(16'(cfg.heater_offline_open_load_enable), r[4][1]);
        chk({cfg.ec_feedback_diag_select, cfg.ec_short_resistance_select}, {r[5][15:14], r[5][11:10]});
        chk(16'(cfg.ec_supply_overcurrent_deglitch), r[5][13:12]);
        chk(16'(cfg.ec_overvoltage_deglitch), r[5][9:8]);
        chk(16'(cfg.ec_overvoltage_response), r[5][5:4]);
        chk(16'(cfg.ec_overcurrent_response), r[5][3]);
        chk(16'(cfg.ec_lowside_pwm_discharge), r[5][2]);
        chk(16'(cfg.ec_discharge_open_load_enable), r[5][1]);
        chk(16'(cfg.ec_max_target_select), r[5][0]);
        chk({cfg.hs_shared_trip_frequency, cfg.hs_shared_trip_deglitch}, r[6][11:8]);
        chk(16'(cfg.hs8_trip_regulation_enable), r[6][4:0]);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int k = 0; k < 8; k++)
            r[k] = (k == 4) ? 16'h0a3c : 16'h0000;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        msk = '{16'h003f, 16'h008f, 16'h3f3f, 16'h0fff, 16'h0ffe, 16'hff3f, 16'h0f1f, 16'h0000};
        {rstn, psel, penable, pwrite, paddr, pwdata, pstrb, hs7_on_resistance_mode} = '0;
        mismatches = 0;
        num_checks = 0;
        do_reset();
        rd_all();
        check_fields();
        // Full-word patterns, reserved bits must stay zero
        foreach (msk[p])
        begin
            for (int k = 0; k < 8; k++)
                wr(k, (p % 2) ? 16'h5555 : ~(16'h5555 << (p % 3)), 4'h3);
            check_fields();
            rd_all();
        end
        // Byte lanes written one at a time
        for (int k = 0; k < 8; k++)
            wr(k, 16'hc3a5, 4'b0001);
        for (int k = 0; k < 8; k++)
            wr(k, 16'h5a3c, 4'b0010);
        rd_all();
        // Every code of the selects that have a decode, and their decoded values
        for (int c = 0; c < 4; c++)
        begin
            wr(1, 16'(c), 4'h3);
            wr(6, 16'(c << 8), 4'h3);
            wr(4, 16'(c << 6), 4'h3);
            wr(5, 16'((c << 4) | (c & 1)), 4'h3);
            check_fields();
            chk(16'(dec.hs7_trip_dg_cycles), 16'((48 - 8 * c) * 25));
            chk(16'(dec.hs_shared_trip_dg_cycles), 16'((48 - 8 * c) * 25));
            chk(16'(dec.heater_monitor_active), 16'(c != 3));
            chk(16'(dec.ec_ov_pull_gate_low), 16'(c == 2));
            chk(16'(dec.ec_max_target_mv), (c & 1) ? 16'd1500 : 16'd1200);
        end
        // Current limits against on-resistance mode
        for (int m = 0; m < 4; m++)
        begin
            @(posedge sys_clk);
            hs7_on_resistance_mode <= m[1];
            wr(2, m[0] ? 16'h2a00 : 16'h1500, 4'h3);
            @(negedge sys_clk);
            chk(16'(dec.cc_limit_ma[0]), m[1] ? (r[2][8] ? 16'd450 : 16'd360) : (r[2][8] ? 16'd330 : 16'd250));
            for (int i = 1; i < 6; i++)
                chk(16'(dec.cc_limit_ma[i]), r[2][8 + i] ? 16'd450 : 16'd350);
        end
        // Unmapped, misaligned and spare places
        apb(1'b0, adr(8), 16'h0000, 4'h0);
        chk(rdv[15:0], 16'h0000);
        chk(16'(errv), 16'h0001);
        apb(1'b1, adr(-1), 16'hffff, 4'h3);
        chk(16'(errv), 16'h0001);
        apb(1'b0, adr(1) + 8'h01, 16'h0000, 4'h0);
        chk(rdv[15:0], 16'h0000);
        chk(16'(errv), 16'h0001);
        wr(7, 16'hffff, 4'h3);
        rd_all();
        check_fields();
        // Reset in mid-run restores the defaults
        do_reset();
        rd_all();
        check_fields();
        end_sim();
    end

endmodule

`default_nettype wire
